/* rtl/pcr_regs.vh */
// Register map and constants for the power, clock and reset controller.
// Assumes an 8-bit register port from the CPU core; addresses are 8 bits.
`ifndef PCR_REGS_VH
`define PCR_REGS_VH
// ****************************************
// Register offsets
// ****************************************
`define PCR_A_SYSCTL 8'h00
`define PCR_A_CLKCTL 8'h01
`define PCR_A_SLEEP 8'h02
`define PCR_A_IRQEN_L 8'h03
`define PCR_A_IRQEN_H 8'h04
`define PCR_A_IRQPD_L 8'h05
`define PCR_A_IRQPD_H 8'h06
`define PCR_A_WDCTL 8'h07
`define PCR_A_STATUS 8'h08
`define PCR_A_NMIEN 8'h09
`define PCR_A_NMIPD 8'h0a
// ****************************************
// Field positions
// ****************************************
`define PCR_SYS_HS_SEL 0
`define PCR_CLK_LS_SEL 0
`define PCR_CLK_LS_ON 1
`define PCR_SLP_FLAG 0
`define PCR_WD_KICK 0
`define PCR_WD_EN 1
`define PCR_WD_DIV_LO 2
`define PCR_WD_DIV_HI 4
// ****************************************
// Clock source encodings and resets
// ****************************************
`define PCR_SRC_RC 2'h0
`define PCR_SRC_HS 2'h1
`define PCR_SRC_LS 2'h2
`define PCR_CLKCTL_RST 8'h02
`define PCR_WDCTL_RST 8'h1e
`define PCR_ZERO8 8'h00
`define PCR_ZERO11 11'h000
// ****************************************
// Vectors and counts
// ****************************************
`define PCR_VEC_IRQ 16'hfff8
`define PCR_VEC_RST 16'hfffa
`define PCR_VEC_NMI 16'hfffc
`define PCR_NSRC 11
`define PCR_WD_BITS 16
`define PCR_WD_ONE 16'h0001
`define PCR_WD_ZERO 16'h0000
`define PCR_SW_WAIT 2'h3
`define PCR_SW_ZERO 2'h0
`define PCR_SW_ONE 2'h1
`endif

/* rtl/pcr_clk_gate.v */
// Glitch-free clock gate for one clock source.
// Assumes the enable is synchronous to CLK; output is a gate enable.
`timescale 1ns/10ps
module pcr_clk_gate (
   // Clock and reset
   input wire CLK,
   input wire RST_N,
   input wire CE,
   // Control
   input wire want,
   input wire other_off,
   // Status
   output reg on_q
);
   // Turn on only after every other source is off, so no short pulse escapes
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         on_q <= 1'b0;
      end else if (CE) begin
         on_q <= want & other_off; // (R19)
      end
   end
endmodule

/* rtl/pcr_top.v */
// Power mode, clock source, reset and interrupt wake control.
// Assumes the CPU core drives the register port on CLK and takes gate
// enables for each oscillator; the source clocks are muxed outside.
//
// Operation
// (R1) Normal, sleep and data-save modes exist
// (R2) High speed uses RC or HS oscillator
// (R3) Reset selects and starts RC oscillator
// (R4) Firmware registers pick the CPU clock source
// (R5) Writing sleep flag enters sleep
// (R6) Sleep gates CPU clock, keeps LS oscillator
// (R7) Sleep still detects timer and pin interrupts
// (R8) Reset or interrupt wakes to full speed; an interrupt wake keeps the source selected before sleep, such as LS
// (R9) Disabling LS while LS selected: data save
// (R10) Only pin interrupt or reset ends data save; key scan and freq count share pending bits 6 and 7 with pins and end it too
// (R11) Firmware selects LS clock before sleeping
// (R12) Watchdog overflow or reset pin resets
// (R13) Reset vector fetch address given on exit
// (R14) Independent watchdog counter overflows into reset
// (R15) Eleven enabled sources share one vector
// (R16) Non-maskable interrupt reserved, reads zero
// (R17) Four port A pin interrupts accepted
// (R18) Shared sources merge onto pending bits
// (R19) Clock source changes are glitch-free
// (R20) Only enabled sources wake from sleep
`timescale 1ns/10ps
`include "pcr_regs.vh"
module pcr_top (
   // Clock, reset, enable
   input wire CLK,
   input wire RST_N,
   input wire CE,
   // Register port
   input wire [7:0] ADDR,
   input wire [7:0] WDATA,
   input wire WR,
   input wire RD,
   output reg [7:0] RDATA,
   // Interrupt sources
   input wire [3:0] PORT_A_IRQ,
   input wire KEY_SCAN_IRQ,
   input wire FREQ_COUNT_IRQ,
   input wire RTC_IRQ,
   input wire TIMER2_IRQ,
   input wire [4:0] INT_IRQ,
   // Clock controls
   output reg RC_ON,
   output reg HS_ON,
   output reg LS_ON,
   output reg CPU_CLK_EN,
   output reg [1:0] CPU_SRC,
   // Core controls
   output reg CORE_RST,
   output reg IRQ,
   output reg [15:0] VECTOR
);
   // ****************************************
   // Mode state
   // ****************************************
   localparam ST_RUN = 3'b001;
   localparam ST_SLEEP = 3'b010;
   localparam ST_SAVE = 3'b100;
   reg [2:0] st_q;
   reg [2:0] st_d;
   reg sys_q;
   reg [7:0] clkctl_q;
   reg [7:0] wdctl_q;
   reg [10:0] irqen_q;
   reg [10:0] pend_q;
   reg [10:0] pend_d;
   reg [`PCR_WD_BITS-1:0] wd_q;
   reg wd_ovf_q;
   reg [1:0] rst_cnt_q;
   // ****************************************
   // Input synchronisers
   // ****************************************
   wire [12:0] raw = {INT_IRQ, TIMER2_IRQ, RTC_IRQ, FREQ_COUNT_IRQ, KEY_SCAN_IRQ,
      PORT_A_IRQ};
   reg [12:0] s1_q;
   reg [12:0] s2_q;
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         s1_q <= 13'h0000;
         s2_q <= 13'h0000;
      end else if (CE) begin
         s1_q <= raw;
         s2_q <= s1_q;
      end
   end
   // Source map: 0..1 pins, 2..5 internal, 6 key or pin2, 7 pin3 or freq, 8 rtc or t2
   wire [10:0] src; // (R17)
   assign src[1:0] = s2_q[1:0];
   assign src[5:2] = s2_q[11:8];
   assign src[6] = s2_q[4] | s2_q[2]; // (R18)
   assign src[7] = s2_q[3] | s2_q[5]; // (R18)
   assign src[8] = s2_q[6] | s2_q[7]; // (R18)
   // Last internal line fills both spare pending bits
   assign src[10:9] = {2{s2_q[12]}};
   wire [10:0] pin_mask = 11'h0c3;
   // ****************************************
   // Clock source selection
   // ****************************************
   wire want_ls = clkctl_q[`PCR_CLK_LS_SEL];
   wire [1:0] want_src = want_ls ? `PCR_SRC_LS :
      (sys_q ? `PCR_SRC_HS : `PCR_SRC_RC); // (R2) (R4)
   wire g_rc;
   wire g_hs;
   wire g_ls;
   wire want_rc = want_src == `PCR_SRC_RC;
   wire want_hs = want_src == `PCR_SRC_HS;
   wire want_lsg = want_src == `PCR_SRC_LS;
   pcr_clk_gate u_rc (.CLK(CLK), .RST_N(RST_N), .CE(CE), .want(want_rc),
      .other_off(~g_hs & ~g_ls), .on_q(g_rc));
   pcr_clk_gate u_hs (.CLK(CLK), .RST_N(RST_N), .CE(CE), .want(want_hs),
      .other_off(~g_rc & ~g_ls), .on_q(g_hs));
   pcr_clk_gate u_ls (.CLK(CLK), .RST_N(RST_N), .CE(CE), .want(want_lsg),
      .other_off(~g_rc & ~g_hs), .on_q(g_ls));
   wire ls_off_req = want_ls & ~clkctl_q[`PCR_CLK_LS_ON];
   // ****************************************
   // Mode machine
   // ****************************************
   wire wake_any = |(pend_q & irqen_q); // (R20)
   wire wake_pin = |(pend_q & irqen_q & pin_mask); // (R10)
   always @* begin
      st_d = st_q;
      case (st_q)
         ST_RUN: begin
            if (ls_off_req) begin
               st_d = ST_SAVE; // (R9)
            end else if (WR && ADDR == `PCR_A_SLEEP && WDATA[`PCR_SLP_FLAG]) begin
               st_d = ST_SLEEP; // (R5)
            end
         end
         ST_SLEEP: begin
            if (wake_any) begin
               st_d = ST_RUN; // (R8)
            end
         end
         ST_SAVE: begin
            if (wake_pin) begin
               st_d = ST_RUN; // (R10)
            end
         end
         default: begin
            st_d = ST_RUN;
         end
      endcase
   end
   // ****************************************
   // Pending flags, set beats clear
   // ****************************************
   always @* begin
      pend_d = pend_q;
      if (WR && ADDR == `PCR_A_IRQPD_L) begin
         pend_d[7:0] = pend_q[7:0] & ~WDATA;
      end
      if (WR && ADDR == `PCR_A_IRQPD_H) begin
         pend_d[10:8] = pend_q[10:8] & ~WDATA[2:0];
      end
      pend_d = pend_d | src; // (R7)
   end
   // ****************************************
   // Registers and watchdog
   // ****************************************
   // Watchdog tick divider from the chosen power of two; the longest setting
   // models the longest overflow period on the low-speed clock.
   wire [2:0] wd_div = wdctl_q[`PCR_WD_DIV_HI:`PCR_WD_DIV_LO];
   wire [`PCR_WD_BITS-1:0] wd_top = {`PCR_WD_BITS{1'b1}} >> (3'h7 - wd_div);
   wire wd_kick = WR && ADDR == `PCR_A_WDCTL && WDATA[`PCR_WD_KICK];
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_q <= ST_RUN;
         sys_q <= 1'b0;
         clkctl_q <= `PCR_CLKCTL_RST; // (R3)
         wdctl_q <= `PCR_WDCTL_RST;
         irqen_q <= `PCR_ZERO11;
         pend_q <= `PCR_ZERO11;
         wd_q <= `PCR_WD_ZERO;
         wd_ovf_q <= 1'b0;
      end else if (CE && wd_ovf_q) begin
         // Watchdog reset reloads this block's reset values, but not the synchronisers or clock gates, so the clock falls back to RC
         st_q <= ST_RUN; // (R12)
         sys_q <= 1'b0;
         clkctl_q <= `PCR_CLKCTL_RST; // (R3)
         wdctl_q <= `PCR_WDCTL_RST;
         irqen_q <= `PCR_ZERO11;
         pend_q <= `PCR_ZERO11;
         wd_q <= `PCR_WD_ZERO;
         wd_ovf_q <= 1'b0;
      end else if (CE) begin
         st_q <= st_d; // (R1)
         pend_q <= pend_d;
         wd_ovf_q <= 1'b0;
         if (WR && ADDR == `PCR_A_SYSCTL) begin
            sys_q <= WDATA[`PCR_SYS_HS_SEL];
         end
         if (WR && ADDR == `PCR_A_CLKCTL) begin
            clkctl_q <= WDATA;
         end else if (st_q == ST_SAVE && wake_pin) begin
            clkctl_q[`PCR_CLK_LS_ON] <= 1'b1; // (R10)
         end
         if (WR && ADDR == `PCR_A_WDCTL) begin
            wdctl_q <= WDATA & 8'hfe;
         end
         if (WR && ADDR == `PCR_A_IRQEN_L) begin
            irqen_q[7:0] <= WDATA;
         end
         if (WR && ADDR == `PCR_A_IRQEN_H) begin
            irqen_q[10:8] <= WDATA[2:0];
         end
         // Independent counter; held at zero when disabled and in data save where its clock is off
         if (wd_kick || !wdctl_q[`PCR_WD_EN] || st_q == ST_SAVE) begin
            wd_q <= `PCR_WD_ZERO;
         end else if (wd_q >= wd_top) begin
            wd_q <= `PCR_WD_ZERO;
            wd_ovf_q <= 1'b1; // (R14)
         end else begin
            wd_q <= wd_q + `PCR_WD_ONE;
         end
      end
   end
   // ****************************************
   // Core reset stretch and outputs
   // ****************************************
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_cnt_q <= `PCR_SW_WAIT;
         CORE_RST <= 1'b1;
         VECTOR <= `PCR_VEC_RST;
         IRQ <= 1'b0;
         RC_ON <= 1'b1;
         HS_ON <= 1'b0;
         LS_ON <= 1'b1;
         CPU_CLK_EN <= 1'b0;
         CPU_SRC <= `PCR_SRC_RC;
         RDATA <= `PCR_ZERO8;
      end else if (CE) begin
         if (wd_ovf_q) begin
            rst_cnt_q <= `PCR_SW_WAIT; // (R12)
         end else if (rst_cnt_q != `PCR_SW_ZERO) begin
            rst_cnt_q <= rst_cnt_q - `PCR_SW_ONE;
         end
         CORE_RST <= wd_ovf_q | (rst_cnt_q != `PCR_SW_ZERO); // (R12)
         IRQ <= wake_any & st_q == ST_RUN; // (R15)
         VECTOR <= (wd_ovf_q || rst_cnt_q != `PCR_SW_ZERO) ? `PCR_VEC_RST : `PCR_VEC_IRQ; // (R13)
         RC_ON <= want_rc | g_rc; // (R3)
         HS_ON <= want_hs | g_hs;
         LS_ON <= clkctl_q[`PCR_CLK_LS_ON] & st_q != ST_SAVE; // (R6) (R9)
         // Gate the core as soon as its slow source is being switched off
         CPU_CLK_EN <= st_q == ST_RUN & ~ls_off_req & (g_rc | g_hs | g_ls); // (R6) (R19)
         CPU_SRC <= g_ls ? `PCR_SRC_LS : (g_hs ? `PCR_SRC_HS : `PCR_SRC_RC);
         RDATA <= `PCR_ZERO8;
         if (RD) begin
            case (ADDR)
               `PCR_A_SYSCTL: RDATA <= {7'h00, sys_q};
               `PCR_A_CLKCTL: RDATA <= clkctl_q;
               `PCR_A_IRQEN_L: RDATA <= irqen_q[7:0];
               `PCR_A_IRQEN_H: RDATA <= {5'h00, irqen_q[10:8]};
               `PCR_A_IRQPD_L: RDATA <= pend_q[7:0];
               `PCR_A_IRQPD_H: RDATA <= {5'h00, pend_q[10:8]};
               `PCR_A_WDCTL: RDATA <= wdctl_q;
               `PCR_A_STATUS: RDATA <= {3'h0, CPU_SRC, st_q};
               default: RDATA <= `PCR_ZERO8; // (R16)
            endcase
         end
      end
   end
endmodule

/* test/pcr_monitor.sv */
// Checker for the power, clock and reset controller ports.
// Assumes CE high; bound to pcr_top from the testbench file.
`timescale 1ns/10ps
module pcr_monitor (
   // Clock and reset
   input wire CLK,
   input wire RST_N,
   // Register port
   input wire [7:0] ADDR,
   input wire [7:0] WDATA,
   input wire WR,
   input wire RD,
   input wire [7:0] RDATA,
   // Controls
   input wire RC_ON,
   input wire LS_ON,
   input wire CPU_CLK_EN,
   input wire [1:0] CPU_SRC,
   input wire CORE_RST,
   input wire IRQ,
   input wire [15:0] VECTOR
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // ****
   // Properties
   // ****
   sequence s_sleep_wr;
      WR && ADDR == 8'h02 && WDATA[0] && !IRQ;
   endsequence
   sequence s_mask_all;
      WR && ADDR == 8'h03 && WDATA == 8'h00 ##2 WR && ADDR == 8'h04 && WDATA == 8'h00;
   endsequence
   a_vec_reset: assert property (CORE_RST |-> VECTOR == 16'hfffa)
      else $error("vector wrong in reset");
   a_nmi_zero: assert property (RD && ADDR[7:1] == 7'h05 |=> RDATA == 8'h00)
      else $error("reserved read not zero");
   a_sleep_gate: assert property (s_sleep_wr |-> ##2 !CPU_CLK_EN)
      else $error("sleep left clock on");
   a_sleep_ls: assert property (s_sleep_wr ##0 LS_ON |-> ##2 LS_ON)
      else $error("sleep stopped slow osc");
   a_reset_rc: assert property ($fell(CORE_RST) |-> RC_ON && CPU_SRC == 2'h0)
      else $error("reset not on rc");
   a_src_osc: assert property (CPU_CLK_EN && CPU_SRC == 2'h2 |-> LS_ON)
      else $error("clock from stopped osc");
   a_mask_irq: assert property (s_mask_all |-> ##2 !IRQ)
      else $error("masked irq raised");
   a_wd_pulse: assert property ($rose(CORE_RST) |-> CORE_RST [*4] ##1 !CORE_RST)
      else $error("reset pulse length");
endmodule

/* test/pcr_core_model.sv */
// Core model: keeps the fetch address and counts clocked cycles.
// Assumes CORE_RST, CPU_CLK_EN and VECTOR arrive on CLK.
`timescale 1ns/10ps
module pcr_core_model (
   // Clock
   input wire CLK,
   // From controller
   input wire CORE_RST,
   input wire CPU_CLK_EN,
   input wire [15:0] VECTOR,
   // Observed
   output reg [15:0] fetch_q,
   output reg [15:0] ticks_q
);
   // ****
   // Fetch and run
   // ****
   always @(posedge CLK) begin
      if (CORE_RST) begin
         fetch_q <= VECTOR;
         ticks_q <= 16'h0000;
      end else if (CPU_CLK_EN) begin
         ticks_q <= ticks_q + 16'h0001;
      end
   end
endmodule

/* test/test_pcr_top.sv */
// Testbench for the power, clock and reset controller.
// Assumes the core model and checker are compiled before it.
`timescale 1ns/10ps
module test_pcr_top;
   reg CLK = 1'b0;
   reg RST_N = 1'b0;
   reg [7:0] ADDR = 8'h00;
   reg [7:0] WDATA = 8'h00;
   reg WR = 1'b0;
   reg RD = 1'b0;
   reg [3:0] PORT_A_IRQ = 4'h0;
   reg KEY_SCAN_IRQ = 1'b0;
   reg FREQ_COUNT_IRQ = 1'b0;
   reg [4:0] INT_IRQ = 5'h00;
   wire [7:0] RDATA;
   wire RC_ON, HS_ON, LS_ON, CPU_CLK_EN, CORE_RST, IRQ;
   wire [1:0] CPU_SRC;
   wire [15:0] VECTOR, fetch_q, ticks_q;
   logic [7:0] exp_q[$];
   logic rd_pend = 1'b0;
   logic [15:0] t0;
   integer fails = 0, num_checks = 0, cycles = 0, n, i, r, seed = 72;
   always #5 CLK = ~CLK;
   pcr_top pcr_top_inst (.CLK(CLK), .RST_N(RST_N), .CE(1'b1), .ADDR(ADDR), .WDATA(WDATA),
      .WR(WR), .RD(RD), .RDATA(RDATA), .PORT_A_IRQ(PORT_A_IRQ), .KEY_SCAN_IRQ(KEY_SCAN_IRQ),
      .FREQ_COUNT_IRQ(FREQ_COUNT_IRQ), .RTC_IRQ(1'b0), .TIMER2_IRQ(1'b0), .INT_IRQ(INT_IRQ),
      .RC_ON(RC_ON), .HS_ON(HS_ON), .LS_ON(LS_ON), .CPU_CLK_EN(CPU_CLK_EN),
      .CPU_SRC(CPU_SRC), .CORE_RST(CORE_RST), .IRQ(IRQ), .VECTOR(VECTOR));
   pcr_core_model pcr_core_model_inst (.CLK(CLK), .CORE_RST(CORE_RST),
      .CPU_CLK_EN(CPU_CLK_EN), .VECTOR(VECTOR), .fetch_q(fetch_q), .ticks_q(ticks_q));
   // ****
   // Tasks
   // ****
   task check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks = num_checks + 1;
      if (seen !== exp) begin
         fails = fails + 1;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      exp_q.push_back(e);
      @(posedge CLK);
      RD <= 1'b0;
   endtask
   task waitc(input integer k);
      repeat (k) @(posedge CLK);
      #1;
   endtask
   task tally_and_finish;
      $display("checks=%0d fails=%0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Read data stand one cycle only, so they are taken at that edge
   always @(posedge CLK) begin
      cycles <= cycles + 1;
      if (rd_pend && exp_q.size() > 0) check(RDATA, exp_q.pop_front());
      rd_pend <= RD;
      if (cycles == 20000) begin
         fails = fails + 1;
         tally_and_finish;
      end
   end
   // ****
   // Scenarios
   // ****
   initial begin
      waitc(12);
      RST_N <= 1'b1;
      for (n = 0; n < 20 && CORE_RST !== 1'b0; n = n + 1) waitc(1);
      check(fetch_q, 16'hfffa);
      check({RC_ON, CPU_SRC, VECTOR}, 19'h4fff8);
      rd(8'h01, 8'h02);
      rd(8'h07, 8'h1e);
      wr(8'h0a, 8'hff);
      rd(8'h0a, 8'h00);
      rd(8'h08, 8'h01);
      wr(8'h00, 8'h01);
      for (n = 0; n < 50 && CPU_SRC !== 2'h1; n = n + 1) waitc(1);
      check({HS_ON, CPU_SRC, CPU_CLK_EN}, 4'hb);
      wr(8'h01, 8'h03);
      for (n = 0; n < 50 && CPU_SRC !== 2'h2; n = n + 1) waitc(1);
      check({LS_ON, CPU_SRC, CPU_CLK_EN}, 4'hd);
      wr(8'h05, 8'hff);
      wr(8'h03, 8'h01);
      wr(8'h02, 8'h01);
      waitc(3);
      t0 = ticks_q;
      rd(8'h08, 8'h12);
      INT_IRQ <= 5'h01;
      waitc(8);
      check({ticks_q, CPU_CLK_EN, LS_ON}, {t0, 2'h1});
      PORT_A_IRQ <= 4'h1;
      for (n = 0; n < 20 && CPU_CLK_EN !== 1'b1; n = n + 1) waitc(1);
      check({CPU_CLK_EN, IRQ}, 2'h3);
      INT_IRQ <= 5'h00;
      PORT_A_IRQ <= 4'h0;
      rd(8'h05, 8'h05);
      wr(8'h03, 8'h00);
      wr(8'h04, 8'h00);
      waitc(2);
      check(IRQ, 1'b0);
      wr(8'h05, 8'hff);
      // Shared sources, random mixes
      for (i = 0; i < 4; i = i + 1) begin
         r = $random(seed);
         KEY_SCAN_IRQ <= r[0];
         PORT_A_IRQ <= {r[2:1], 2'h0};
         FREQ_COUNT_IRQ <= r[3];
         waitc(5);
         KEY_SCAN_IRQ <= 1'b0;
         PORT_A_IRQ <= 4'h0;
         FREQ_COUNT_IRQ <= 1'b0;
         waitc(4);
         rd(8'h05, {r[2] | r[3], r[0] | r[1], 6'h00});
         wr(8'h05, 8'hff);
      end
      wr(8'h03, 8'h05);
      wr(8'h01, 8'h01);
      waitc(4);
      check({CPU_CLK_EN, LS_ON}, 2'h0);
      rd(8'h08, 8'h14);
      INT_IRQ <= 5'h01;
      waitc(8);
      check(LS_ON, 1'b0);
      PORT_A_IRQ <= 4'h1;
      for (n = 0; n < 20 && LS_ON !== 1'b1; n = n + 1) waitc(1);
      check(LS_ON, 1'b1);
      INT_IRQ <= 5'h00;
      PORT_A_IRQ <= 4'h0;
      // Kick in the same write that sets the shorter top, so it starts from zero
      wr(8'h07, 8'h03);
      for (n = 0; n < 700 && CORE_RST !== 1'b1; n = n + 1) waitc(1);
      check({n >= 500, n < 700}, 2'h3);
      waitc(2);
      check({RC_ON, CPU_SRC}, 3'h4);
      RST_N <= 1'b0;
      waitc(2);
      check(CORE_RST, 1'b1);
      RST_N <= 1'b1;
      waitc(8);
      tally_and_finish;
   end
endmodule
bind pcr_top pcr_monitor pcr_monitor_inst (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR),
   .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .RC_ON(RC_ON), .LS_ON(LS_ON),
   .CPU_CLK_EN(CPU_CLK_EN), .CPU_SRC(CPU_SRC), .CORE_RST(CORE_RST), .IRQ(IRQ),
   .VECTOR(VECTOR));
